/* File: common/irq_arb_if.sv */
/*
 * Carrier between the handler and its arbiter: masked request vectors
 * per level going in, the winning source and its level coming out.
 * Assumes both ends sit on the same clock; the path is combinational.
 */
`timescale 1ns/1ps
interface irq_arb_if #(
    parameter int N = irq_pkg::NUM_SOURCES
);
    logic [N-1:0]                  highReq;
    logic [N-1:0]                  lowReq;
    logic                          winValid;
    logic [irq_pkg::SRC_ID_W-1:0] winSrc;
    logic                          winHigh;

    modport handler (
        output highReq,
        output lowReq,
        input  winValid,
        input  winSrc,
        input  winHigh
    );

    modport arbiter (
        input  highReq,
        input  lowReq,
        output winValid,
        output winSrc,
        output winHigh
    );
endinterface

/* File: common/irq_pkg.sv */
/*
 * Shared constants for the two-level interrupt handler: source count,
 * register field positions, reset values, vector layout and call timing.
 * Assumes one system clock and a CPU core that reports instruction
 * boundaries and completed returns as single-cycle pulses.
 */
// Operation
// - eighteen sources arbitrated, each assignable to low or high level
// - a source's valid condition sets its pending flag to one
// - pending flags set regardless of enable bits
// - enabled source with set flag raises a request to the CPU
// - disabled source is ignored, no request, execution continues
// - CPU finishes current instruction, then long calls the source vector
// - every routine ends in a return resuming the interrupted flow
// - each source has its own enable bit in enable registers
// - individual enables act only while global enable bit seven is set
// - global enable at zero blocks every source
// - conditions raised while globally disabled stay pending for later
// - hardware clears some flags on vectoring; software clears the rest
// - flag still set after return re-requests after one more instruction
// - software writing one to a flag acts as a real event
// - high level preempts low routine; nothing preempts high routine
// - per-source priority bits select level; reset gives low level
// - simultaneous requests: higher programmed level served first
// - equal levels resolved by fixed per-source order
// - requests sampled and priority decoded every clock cycle
// - shortest request-to-routine time is seven clocks
// - equal or lower request waits for return plus one instruction
package irq_pkg;

    localparam int NUM_SOURCES = 18;
    localparam int SRC_ID_W    = 5;
    localparam int REG_W       = 8;

    // enable register layout
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam int BASE_FIELD_BITS   = 7;
    localparam int EXT_FIELD_BITS    = 2 * REG_W;

    // reset values: everything off, every source at low level
    localparam logic [7:0] ENABLE_RESET   = 8'h00;
    localparam logic [7:0] PRIORITY_RESET = 8'h00;

    // vector table: first vector and spacing between vectors
    localparam int          VECTOR_W    = 16;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_STEP = 16'h0008;

    // sources whose flags hardware clears when vectoring
    localparam logic [17:0] HW_CLEAR_MASK = 18'h0000F;

    // timing in system clock cycles
    localparam int DETECT_CYCLES      = 1;
    localparam int MIN_INSTR_CYCLES   = 1;
    localparam int LONG_CALL_CYCLES   = 5;
    localparam int MIN_LATENCY_CYCLES =
        DETECT_CYCLES + MIN_INSTR_CYCLES + LONG_CALL_CYCLES;
    localparam int CALL_CNT_W = 3;

    typedef enum logic [0:0] {
        LEVEL_LOW,
        LEVEL_HIGH
    } level_type;

endpackage

/* File: logic/irq_arbiter.sv */
/*
 * Two-level fixed-order arbiter: any high-level request beats every
 * low-level one; within a level the lowest source number wins.
 * Assumes request vectors are already masked by enables.
 */
`timescale 1ns/1ps
module irq_arbiter #(
    parameter int N = irq_pkg::NUM_SOURCES
) (
    irq_arb_if.arbiter arb
);

    function automatic logic [irq_pkg::SRC_ID_W-1:0] firstSet(
        input logic [N-1:0] v
    );
        logic [irq_pkg::SRC_ID_W-1:0] idx;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = irq_pkg::SRC_ID_W'(i);
            end
        end
        return idx;
    endfunction

    always_comb begin
        arb.winValid = 1'b0;
        arb.winHigh  = 1'b0;
        arb.winSrc   = '0;
        if (|arb.highReq) begin
            arb.winValid = 1'b1;
            arb.winHigh  = 1'b1;
            arb.winSrc   = firstSet(arb.highReq);
        end else if (|arb.lowReq) begin
            arb.winValid = 1'b1;
            arb.winSrc   = firstSet(arb.lowReq);
        end
    end

endmodule

/* File: logic/two_level_interrupt_handler.sv */
/*
 * Two-level interrupt handler: holds the pending flags, masks them with
 * per-source and global enables, arbitrates by level and fixed order,
 * steers the CPU into a long call to the source vector and tracks the
 * nesting of running service routines.
 * Assumes peripherals and the CPU core share mclk, so no synchronisers;
 * instrDone and retiDone are one-cycle pulses and never coincide.
 */
`timescale 1ns/1ps
module two_level_interrupt_handler #(
    parameter int          N            = irq_pkg::NUM_SOURCES,
    parameter logic [17:0] HW_CLEAR     = irq_pkg::HW_CLEAR_MASK,
    parameter int          CALL_CYCLES  = irq_pkg::LONG_CALL_CYCLES
) (
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic [N-1:0]                  periphEvent,
    input  wire logic [N-1:0]                  swFlagSet,
    input  wire logic [N-1:0]                  swFlagClear,
    input  wire logic [7:0]                    irqEnableReg,
    input  wire logic [7:0]                    extIrqEnableReg1,
    input  wire logic [7:0]                    extIrqEnableReg2,
    input  wire logic [7:0]                    irqPriorityReg,
    input  wire logic [7:0]                    extIrqPriorityReg1,
    input  wire logic [7:0]                    extIrqPriorityReg2,
    input  wire logic                          instrDone,
    input  wire logic                          retiDone,
    output logic [N-1:0]                       pendingFlags,
    output logic                               irqRequest,
    output logic                               longCallActive,
    output logic [irq_pkg::VECTOR_W-1:0]       vectorAddr,
    output logic [irq_pkg::SRC_ID_W-1:0]       vectorSrc,
    output logic                               serviceStart,
    output logic                               highActive,
    output logic                               lowActive
);

    // the field map covers seven base bits plus two extension registers
    localparam int MAP_W = irq_pkg::BASE_FIELD_BITS
                         + irq_pkg::EXT_FIELD_BITS;

    // highest service address, which must still fit the vector output
    localparam int LAST_VECTOR = int'(irq_pkg::VECTOR_BASE)
                               + (N - 1) * int'(irq_pkg::VECTOR_STEP);
    localparam int CALL_MAX    = (1 << irq_pkg::CALL_CNT_W) - 1;

    // parameter sets that the logic cannot serve stop the elaboration
    if (N < 1 || N > MAP_W) begin : gBadCount
        $error("source count outside what the register map holds");
    end
    if (N > (1 << irq_pkg::SRC_ID_W)) begin : gBadId
        $error("source number does not fit its id field");
    end
    if (N > $bits(HW_CLEAR)) begin : gBadClear
        $error("hardware clear mask is narrower than the source count");
    end
    if (LAST_VECTOR >= (1 << irq_pkg::VECTOR_W)) begin : gBadVector
        $error("service address table does not fit the vector width");
    end
    if (CALL_CYCLES < 1 || CALL_CYCLES > CALL_MAX) begin : gBadCall
        $error("long call length does not fit its counter");
    end

    typedef enum logic [0:0] {
        ST_RUN,
        ST_CALL
    } vec_state_type;

    vec_state_type                      state_r;
    logic [N-1:0]                       pend_r;
    logic [N-1:0]                       pend_nxt;
    logic [N-1:0]                       hwClear;
    logic [N-1:0]                       srcEnabled;
    logic [N-1:0]                       srcHigh;
    logic [MAP_W-1:0]                   enableMap;
    logic [MAP_W-1:0]                   priorityMap;
    logic                               globalIrqEnable;
    logic                               canTake;
    logic                               accept;
    logic                               candLive;
    logic                               callLast;
    logic [irq_pkg::CALL_CNT_W-1:0]     callCnt_r;
    logic                               irqRequest_r;
    logic [irq_pkg::SRC_ID_W-1:0]       reqSrc_r;
    logic                               reqHigh_r;
    logic                               longCall_r;
    logic [irq_pkg::VECTOR_W-1:0]       vectorAddr_r;
    logic [irq_pkg::SRC_ID_W-1:0]       vectorSrc_r;
    logic                               serviceStart_r;
    logic                               highActive_r;
    logic                               lowActive_r;

    irq_arb_if #(.N(N)) arbBus ();

    irq_arbiter #(.N(N)) arbiter (
        .arb (arbBus.arbiter)
    );

    // a request may start a routine only if it outranks every running one
    function automatic logic levelAllowed(
        input logic isHigh,
        input logic hiRun,
        input logic loRun
    );
        return isHigh ? !hiRun : (!hiRun && !loRun);
    endfunction

    function automatic logic [irq_pkg::VECTOR_W-1:0] vectorOf(
        input logic [irq_pkg::SRC_ID_W-1:0] src
    );
        logic [irq_pkg::VECTOR_W-1:0] offs;
        offs = irq_pkg::VECTOR_STEP
             * irq_pkg::VECTOR_W'(src);
        return irq_pkg::VECTOR_BASE + offs;
    endfunction

    // one-hot mask of a source number; shared by the hardware clear and
    // the check that the latched candidate is still serviceable
    function automatic logic [N-1:0] oneHot(
        input logic [irq_pkg::SRC_ID_W-1:0] src
    );
        logic [N-1:0] m;
        m = '0;
        for (int i = 0; i < N; i++) begin
            m[i] = (src == irq_pkg::SRC_ID_W'(i));
        end
        return m;
    endfunction

    assign globalIrqEnable =
        irqEnableReg[irq_pkg::GLOBAL_ENABLE_BIT];

    assign enableMap = {extIrqEnableReg2, extIrqEnableReg1,
                        irqEnableReg[irq_pkg::BASE_FIELD_BITS-1:0]};
    assign priorityMap = {extIrqPriorityReg2, extIrqPriorityReg1,
                          irqPriorityReg[irq_pkg::BASE_FIELD_BITS-1:0]};

    // per-source masking; a disabled flag simply stays pending
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gSrc
            assign srcEnabled[g] = enableMap[g] && globalIrqEnable;
            assign srcHigh[g]    = priorityMap[g];
            assign arbBus.highReq[g] = pend_r[g] && srcEnabled[g]
                                    && srcHigh[g];
            assign arbBus.lowReq[g]  = pend_r[g] && srcEnabled[g]
                                    && !srcHigh[g];
        end
    endgenerate

    // only the sources marked in the mask lose their flag on vectoring
    assign hwClear = accept ? (HW_CLEAR[N-1:0] & oneHot(reqSrc_r))
                            : '0;

    // sampled every cycle so the top candidate and its legality are fresh
    assign canTake = arbBus.winValid
                  && levelAllowed(arbBus.winHigh, highActive_r,
                                  lowActive_r);

    // the candidate was latched a cycle earlier; if its flag was cleared
    // or its enables dropped since, it is not vectored to
    assign candLive = |(pend_r & srcEnabled & oneHot(reqSrc_r));

    // vector only at an instruction boundary; retiDone is not one, so the
    // instruction after a return always completes before re-entry
    assign accept = (state_r == ST_RUN) && irqRequest_r && candLive
                 && instrDone && !retiDone;

    // set wins over every clear so no event is lost on a clearing cycle
    always_comb begin
        pend_nxt = pend_r & ~swFlagClear & ~hwClear;
        pend_nxt = pend_nxt | periphEvent;
        pend_nxt = pend_nxt | swFlagSet;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pend_r <= '0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // detection stage: one registered cycle between flag and request
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irqRequest_r <= 1'b0;
        end else begin
            irqRequest_r <= canTake && (state_r == ST_RUN)
                         && !accept;
        end
    end

    // the winner is latched every cycle beside the request it belongs to
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reqSrc_r  <= '0;
            reqHigh_r <= 1'b0;
        end else begin
            reqSrc_r  <= arbBus.winSrc;
            reqHigh_r <= arbBus.winHigh;
        end
    end

    // last count of the long call; accept and this never coincide
    assign callLast = (state_r == ST_CALL) && (callCnt_r == '0);

    // long call sequencer: counts the call cycles down to zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r   <= ST_RUN;
            callCnt_r <= '0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (accept) begin
                        state_r   <= ST_CALL;
                        callCnt_r <= irq_pkg::CALL_CNT_W'(CALL_CYCLES - 1);
                    end
                end
                ST_CALL: begin
                    if (callLast) begin
                        state_r <= ST_RUN;
                    end else begin
                        callCnt_r <= callCnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // the call strobe stands from the accept edge through the last count
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            longCall_r <= 1'b0;
        end else if (accept) begin
            longCall_r <= 1'b1;
        end else if (callLast) begin
            longCall_r <= 1'b0;
        end
    end

    // the routine starts in the cycle right after the call strobe falls
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            serviceStart_r <= 1'b0;
        end else begin
            serviceStart_r <= callLast;
        end
    end

    // vector address held from the accept until the next accept
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            vectorAddr_r <= irq_pkg::VECTOR_BASE;
        end else if (accept) begin
            vectorAddr_r <= vectorOf(reqSrc_r);
        end
    end

    // source number of the last vectoring, held like the address
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            vectorSrc_r <= '0;
        end else if (accept) begin
            vectorSrc_r <= reqSrc_r;
        end
    end

    // nesting: at most one low routine under one high routine; a return
    // always ends the innermost, which is the high one when both run
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            highActive_r <= 1'b0;
        end else if (accept && reqHigh_r) begin
            highActive_r <= 1'b1;
        end else if (retiDone) begin
            highActive_r <= 1'b0;
        end
    end

    // the low level ends only on a return made while no high routine runs
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            lowActive_r <= 1'b0;
        end else if (accept && !reqHigh_r) begin
            lowActive_r <= 1'b1;
        end else if (retiDone && !highActive_r) begin
            lowActive_r <= 1'b0;
        end
    end

    assign pendingFlags   = pend_r;
    assign irqRequest     = irqRequest_r;
    assign longCallActive = longCall_r;
    assign vectorAddr     = vectorAddr_r;
    assign vectorSrc      = vectorSrc_r;
    assign serviceStart   = serviceStart_r;
    assign highActive     = highActive_r;
    assign lowActive      = lowActive_r;

endmodule

/* File: sim/cpu_model.sv */
/* Behavioural CPU core: reports instruction boundaries and returns.
   Assumes the bench asks for returns through retiCmd, one cycle long. */
`timescale 1ns/1ps
module cpu_model (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic longCallActive,
    input  wire logic retiCmd,
    input  wire logic slowCpu,
    output logic      instrDone,
    output logic      retiDone
);
    logic       retiPend_r;
    logic [1:0] divCnt_r;
    always_ff @(posedge mclk) begin
        retiPend_r <= reset_n && retiCmd;
    end
    // outputs move on the falling edge so the handler samples them settled
    always @(negedge mclk) begin
        divCnt_r  <= (divCnt_r == 2'h2 || !reset_n) ? 2'h0 : divCnt_r + 2'h1;
        retiDone  <= retiPend_r;
        // stalled while the long call runs; slow mode is a 3-cycle opcode
        instrDone <= reset_n && !retiPend_r && !longCallActive
                     && (!slowCpu || divCnt_r == 2'h0);
    end
endmodule

/* File: sim/irq_chk.sv */
/* Port-level assertions for the two-level interrupt handler.
   Assumes it is bound to the handler top and sees one clock domain. */
`timescale 1ns/1ps
module irq_chk #(
    parameter int N = 18
) (
    input wire logic         mclk,
    input wire logic         reset_n,
    input wire logic [N-1:0] periphEvent,
    input wire logic [N-1:0] swFlagSet,
    input wire logic [7:0]   irqEnableReg,
    input wire logic [7:0]   extIrqEnableReg1,
    input wire logic [7:0]   extIrqEnableReg2,
    input wire logic         retiDone,
    input wire logic [N-1:0] pendingFlags,
    input wire logic         irqRequest,
    input wire logic         longCallActive,
    input wire logic [15:0]  vectorAddr,
    input wire logic [4:0]   vectorSrc,
    input wire logic         serviceStart,
    input wire logic         highActive,
    input wire logic         lowActive
);
    logic [N-1:0] enMask;
    assign enMask = {extIrqEnableReg2[2:0], extIrqEnableReg1,
                     irqEnableReg[6:0]};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_call;
        $rose(longCallActive) |->
            longCallActive [*5] ##1 (!longCallActive && serviceStart);
    endproperty
    property p_quiet;
        longCallActive |-> !irqRequest;
    endproperty
    property p_vec;
        $rose(longCallActive) |->
            vectorAddr == irq_pkg::VECTOR_BASE + {8'h00, vectorSrc, 3'h0};
    endproperty
    property p_set;
        (|periphEvent) |=>
            (pendingFlags & $past(periphEvent)) == $past(periphEvent);
    endproperty
    property p_sw;
        (|swFlagSet) |=>
            (pendingFlags & $past(swFlagSet)) == $past(swFlagSet);
    endproperty
    property p_req;
        irqRequest && !$past(longCallActive) |->
            $past(irqEnableReg[7] && (|(pendingFlags & enMask)));
    endproperty
    property p_nohi;
        $rose(longCallActive) |-> !$past(highActive);
    endproperty
    property p_lopre;
        $rose(longCallActive) && $past(lowActive) |-> highActive;
    endproperty
    property p_rethi;
        retiDone && highActive |=>
            !highActive && lowActive == $past(lowActive);
    endproperty
    property p_retlo;
        retiDone && !highActive |=> !lowActive;
    endproperty
    a_call: assert property (p_call)
        else $error("long call length or start pulse wrong");
    a_quiet: assert property (p_quiet)
        else $error("request raised during long call");
    a_vec: assert property (p_vec)
        else $error("vector address does not match source");
    a_set: assert property (p_set)
        else $error("event did not set its flag");
    a_sw: assert property (p_sw)
        else $error("software set did not set its flag");
    a_req: assert property (p_req)
        else $error("request without enabled pending flag");
    a_nohi: assert property (p_nohi)
        else $error("high routine was preempted");
    a_lopre: assert property (p_lopre)
        else $error("low routine preempted by non-high request");
    a_rethi: assert property (p_rethi)
        else $error("return from high routine restored wrong level");
    a_retlo: assert property (p_retlo)
        else $error("return from low routine left it active");
    c_call: cover property ($rose(longCallActive));
    c_nest: cover property (highActive && lowActive);
    c_return_from_irq_instr: cover property (retiDone && highActive);
endmodule

/* File: sim/tb.sv */
/* Self-checking bench for the two-level interrupt handler.
   Assumes the checker and the CPU model files are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failCount++; \
    $display("BAD %0t %h %h", $time, (g), (e)); end end
module tb;
    localparam int N = 18;
    logic mclk = 0, reset_n = 0, instrDone, retiDone, irqRequest;
    logic retiCmd = 0, slowCpu = 0, longCallActive, serviceStart;
    logic highActive, lowActive;
    logic [N-1:0] periphEvent = '0, swFlagSet = '0, swFlagClear = '0;
    logic [N-1:0] pendingFlags;
    logic [7:0] ie = '0, e1 = '0, e2 = '0, p0 = '0, p1 = '0, p2 = '0;
    logic [15:0] vectorAddr;
    logic [4:0] vectorSrc;
    int failCount = 0, checks = 0, cyc = 0, n;
    two_level_interrupt_handler #(.N(N)) dut (.mclk(mclk),
        .reset_n(reset_n), .periphEvent(periphEvent),
        .swFlagSet(swFlagSet), .swFlagClear(swFlagClear),
        .irqEnableReg(ie), .extIrqEnableReg1(e1), .extIrqEnableReg2(e2),
        .irqPriorityReg(p0), .extIrqPriorityReg1(p1),
        .extIrqPriorityReg2(p2), .instrDone(instrDone),
        .retiDone(retiDone), .pendingFlags(pendingFlags),
        .irqRequest(irqRequest), .longCallActive(longCallActive),
        .vectorAddr(vectorAddr), .vectorSrc(vectorSrc),
        .serviceStart(serviceStart), .highActive(highActive),
        .lowActive(lowActive));
    cpu_model u_cpu (.mclk(mclk), .reset_n(reset_n),
        .longCallActive(longCallActive), .retiCmd(retiCmd),
        .slowCpu(slowCpu), .instrDone(instrDone), .retiDone(retiDone));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic closeOut;
        if (failCount == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc >= 5000) begin
            failCount++;
            closeOut();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic pulse(input int kind, input logic [N-1:0] m);
        if (kind == 0) periphEvent = m;
        else if (kind == 1) swFlagSet = m;
        else swFlagClear = m;
        tick(1);
        periphEvent = '0;
        swFlagSet = '0;
        swFlagClear = '0;
    endtask
    task automatic cfg(input logic [7:0] a, b, c, d, e, f);
        {ie, e1, e2, p0, p1, p2} = {a, b, c, d, e, f};
    endtask
    task automatic return_from_irq_instr;
        retiCmd = 1'b1;
        tick(1);
        retiCmd = 1'b0;
        tick(2);
    endtask
    task automatic expectVec(input logic [4:0] s);
        for (int i = 0; i < 60 && serviceStart !== 1'b1; i++) tick(1);
        `CHK(serviceStart, 1'b1)
        `CHK(vectorSrc, s)
        `CHK(vectorAddr, 16'h0003 + {8'h00, s, 3'h0})
    endtask
    task automatic sBasic;
        `CHK({irqRequest, highActive, lowActive}, 3'h0)
        cfg(8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        periphEvent = 18'h00001;
        for (n = 0; n < 40 && serviceStart !== 1'b1; n++) begin
            tick(1);
            periphEvent = '0;
        end
        `CHK(n, irq_pkg::MIN_LATENCY_CYCLES + 1)
        expectVec(5'h00);
        `CHK({lowActive, pendingFlags[0]}, 2'h2)
        return_from_irq_instr();
        `CHK(lowActive, 1'b0)
    endtask
    task automatic sMasked;
        cfg(8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        pulse(0, 18'h00010);
        tick(6);
        `CHK({irqRequest, pendingFlags[4]}, 2'h1)
        cfg(8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        tick(6);
        `CHK(irqRequest, 1'b0)
        ie = 8'h90;
        expectVec(5'h04);
        `CHK(pendingFlags[4], 1'b1)
        return_from_irq_instr();
        expectVec(5'h04);
        pulse(2, 18'h00010);
        return_from_irq_instr();
        `CHK({lowActive, pendingFlags}, 19'h0)
    endtask
    task automatic sOrder;
        cfg(8'h8E, 8'h00, 8'h04, 8'h00, 8'h00, 8'h04);
        pulse(1, 18'h20002);
        expectVec(5'h11);
        `CHK(highActive, 1'b1)
        pulse(2, 18'h20000);
        return_from_irq_instr();
        expectVec(5'h01);
        `CHK({highActive, lowActive}, 2'h1)
        return_from_irq_instr();
        pulse(1, 18'h0000C);
        expectVec(5'h02);
        return_from_irq_instr();
        expectVec(5'h03);
        return_from_irq_instr();
    endtask
    task automatic sNest;
        slowCpu = 1'b1;
        cfg(8'hC0, 8'h60, 8'h00, 8'h00, 8'h60, 8'h00);
        pulse(0, 18'h00040);
        expectVec(5'h06);
        pulse(0, 18'h01000);
        expectVec(5'h0C);
        `CHK({highActive, lowActive}, 2'h3)
        pulse(0, 18'h02000);
        tick(12);
        `CHK(vectorSrc, 5'h0C)
        pulse(2, 18'h01000);
        return_from_irq_instr();
        expectVec(5'h0D);
        pulse(2, 18'h02000);
        return_from_irq_instr();
        `CHK({highActive, lowActive}, 2'h1)
        pulse(2, 18'h00040);
        return_from_irq_instr();
        `CHK(lowActive, 1'b0)
        slowCpu = 1'b0;
    endtask
    initial begin
        tick(20);
        reset_n = 1'b1;
        tick(2);
        sBasic();
        sMasked();
        sOrder();
        sNest();
        closeOut();
    end
endmodule
bind two_level_interrupt_handler irq_chk #(.N(N)) u_chk (.mclk(mclk),
    .reset_n(reset_n), .periphEvent(periphEvent), .swFlagSet(swFlagSet),
    .irqEnableReg(irqEnableReg), .extIrqEnableReg1(extIrqEnableReg1),
    .extIrqEnableReg2(extIrqEnableReg2), .retiDone(retiDone),
    .pendingFlags(pendingFlags), .irqRequest(irqRequest),
    .longCallActive(longCallActive), .vectorAddr(vectorAddr),
    .vectorSrc(vectorSrc), .serviceStart(serviceStart),
    .highActive(highActive), .lowActive(lowActive));
